// *** rtl/pcm_port_map.vh ***
// Constants for the companding codec serial PCM port and timing block
`ifndef PCM_PORT_MAP_VH
`define PCM_PORT_MAP_VH
// Clock select codes (three-level pin resolved to two bits)
`define CLK_SEL_2048K 2'h0
`define CLK_SEL_256K 2'h1
`define CLK_SEL_1544K 2'h2
// Master clock edges per 256 kHz filter tick, per clock select
`define DIV_LPF_2048K 8'h08
`define DIV_LPF_256K 8'h01
`define DIV_LPF_1544K 8'h06
// Master clock edges per 8 kHz sample period, less one, per clock select
`define DIV_FRAME_2048K 8'hFF
`define DIV_FRAME_256K 8'h1F
`define DIV_FRAME_1544K 8'hC0
// 256 kHz ticks per 64 kHz tick, less one
`define DIV_HPF 2'h3
// Conversion time and strobe watchdog
`define CONV_TIME_NS 32'h00011940
`define CLK_PERIOD_NS 32'h00000004
`define STROBE_IDLE_NS 32'h0003D090
// Idle squelch: qualifying words in 250 ms at 8 kHz
`define SQUELCH_WORDS 12'h7D0
// Word and frame geometry
`define WORD_BITS 4'h8
`define SIG_FRAMES 4'hB
`define SIG_FRAME_A 4'h5
`define SIG_FRAME_B 4'hB
// Code words
`define MU_POS0 8'hFF
`define MU_NEG0 8'h7F
`define MU_POS1 8'hFE
`define MU_NEG1 8'h7E
`define A_POS0 8'hD5
`define A_NEG0 8'h55
`define A_POS1 8'hD4
`define A_NEG1 8'h54
`define ALL_ZERO 8'h00
`define ZERO_SUBST 8'h02
`endif

// *** rtl/pcm_port.v ***
// Serial PCM port, clock divider, squelch and A/B signalling of a companding codec
// Behaviour
// - Shift eight-bit transmit word out serially
// - Strobe clears bit counter; release after eighth
// - Filter timing divided from master clock
// - Supply 256 kHz low-pass filter tick
// - Supply 64 kHz high-pass filter tick
// - Sample per frame, convert within 72 us
// - Mu-law replaces an all-zero converted code with 02
// - 250 ms idle codes give steady +0
// - Other code leaves squelch, restarts timer
// - Receive shift loads one word per frame
// - Clear pulse zeroes hold each period
// - Every sixth frame LSB carries signalling
// - B bit six frames after A
// - Transmit bits on rising shift edges
// - Receive bits on falling shift edges
// - Power down on pin low or idle strobes
`include "pcm_port_map.vh"
module pcm_port #(
   parameter CONV_CYCLES = `CONV_TIME_NS / `CLK_PERIOD_NS,
   parameter IDLE_CYCLES = `STROBE_IDLE_NS / `CLK_PERIOD_NS
) (
   // Clock and reset
   input wire clk_i,
   input wire reset_n_i,
   // Timing and mode inputs
   input wire master_timing_clock_i,
   input wire [1:0] clk_sel_i,
   input wire power_down_n_i,
   input wire mu_law_i,
   input wire squelch_en_i,
   input wire ab_enable_i,
   // Transmit side
   input wire tx_strobe_i,
   input wire tx_shift_i,
   input wire [7:0] tx_code_i,
   input wire tx_sig_a_i,
   input wire tx_sig_b_i,
   output reg pcm_out_o,
   output reg pcm_out_oe_n_o,
   // Receive side
   input wire rx_strobe_i,
   input wire rx_shift_i,
   input wire rx_pcm_i,
   output reg [7:0] rx_word_o,
   output reg rx_word_valid_o,
   output reg rx_sig_a_o,
   output reg rx_sig_b_o,
   output reg hold_clear_o,
   // Filter and converter timing
   output reg lpf_tick_o,
   output reg hpf_tick_o,
   output reg sample_o,
   output reg convert_done_o,
   output reg power_down_o
);

   reg mclk_d_reg;
   reg tx_strobe_d_reg;
   reg tx_shift_d_reg;
   reg rx_strobe_d_reg;
   reg rx_shift_d_reg;
   reg [7:0] lpf_cnt_reg;
   reg [7:0] frame_cnt_reg;
   reg [1:0] hpf_cnt_reg;
   reg [15:0] conv_cnt_reg;
   reg conv_busy_reg;
   reg [7:0] tx_hold_reg;
   reg [7:0] tx_shreg_reg;
   reg [3:0] tx_bits_reg;
   reg [3:0] tx_frame_reg;
   reg [11:0] idle_words_reg;
   reg squelched_reg;
   reg [7:0] rx_shreg_reg;
   reg [3:0] rx_bits_reg;
   reg [3:0] rx_frame_reg;
   reg [17:0] idle_cnt_reg;
   reg [7:0] lpf_div;
   reg [7:0] frame_div;
   reg [7:0] pos0_word;
   reg idle_code;
   reg [7:0] code_next;
   wire mclk_rise = master_timing_clock_i & ~mclk_d_reg;
   wire tx_strobe_rise = tx_strobe_i & ~tx_strobe_d_reg;
   wire tx_shift_rise = tx_shift_i & ~tx_shift_d_reg;
   wire rx_strobe_rise = rx_strobe_i & ~rx_strobe_d_reg;
   wire rx_shift_fall = ~rx_shift_i & rx_shift_d_reg;
   wire powered = power_down_n_i & ~power_down_o;
   wire [7:0] rx_word_next = {rx_shreg_reg[6:0], rx_pcm_i}; // Word with the final bit shifted in

   // Divide ratios follow the clock select; a mismatch mistimes both the filter ticks and the sample period
   always @* begin
      case (clk_sel_i)
         `CLK_SEL_256K: begin
            lpf_div = `DIV_LPF_256K;
            frame_div = `DIV_FRAME_256K;
         end
         `CLK_SEL_1544K: begin
            lpf_div = `DIV_LPF_1544K;
            frame_div = `DIV_FRAME_1544K;
         end
         default: begin
            lpf_div = `DIV_LPF_2048K;
            frame_div = `DIV_FRAME_2048K;
         end
      endcase
   end

   // Idle code detection and the +0 word of the selected law
   always @* begin
      pos0_word = mu_law_i ? `MU_POS0 : `A_POS0;
      if (mu_law_i) begin
         idle_code = (tx_code_i == `MU_POS0) || (tx_code_i == `MU_NEG0) ||
                     (tx_code_i == `MU_POS1) || (tx_code_i == `MU_NEG1);
      end else begin
         idle_code = (tx_code_i == `A_POS0) || (tx_code_i == `A_NEG0) ||
                     (tx_code_i == `A_POS1) || (tx_code_i == `A_NEG1);
      end
      code_next = tx_code_i;
      if (squelch_en_i && squelched_reg && idle_code) begin
         code_next = pos0_word;
      end
      if (mu_law_i && (code_next == `ALL_ZERO)) begin
         code_next = `ZERO_SUBST;
      end
   end

   // Edge history kept out of reset, so a pulled-up strobe shows no false edge after it
   always @(posedge clk_i) begin
      mclk_d_reg <= master_timing_clock_i;
      tx_strobe_d_reg <= tx_strobe_i;
      tx_shift_d_reg <= tx_shift_i;
      rx_strobe_d_reg <= rx_strobe_i;
      rx_shift_d_reg <= rx_shift_i;
   end

   // Filter ticks and sample period, all from master clock edges
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         lpf_cnt_reg <= 8'h00;
         frame_cnt_reg <= 8'h00;
         hpf_cnt_reg <= 2'h0;
         lpf_tick_o <= 1'b0;
         hpf_tick_o <= 1'b0;
         sample_o <= 1'b0;
      end else begin
         lpf_tick_o <= 1'b0;
         hpf_tick_o <= 1'b0;
         sample_o <= 1'b0;
         if (mclk_rise && powered) begin
            if (lpf_cnt_reg >= lpf_div - 8'h01) begin
               lpf_cnt_reg <= 8'h00;
               lpf_tick_o <= 1'b1;
               hpf_cnt_reg <= hpf_cnt_reg + 2'h1;
               if (hpf_cnt_reg == `DIV_HPF) begin
                  hpf_tick_o <= 1'b1;
               end
            end else begin
               lpf_cnt_reg <= lpf_cnt_reg + 8'h01;
            end
            if (frame_cnt_reg == frame_div) begin
               frame_cnt_reg <= 8'h00;
               sample_o <= 1'b1;
            end else begin
               frame_cnt_reg <= frame_cnt_reg + 8'h01;
            end
         end
      end
   end

   // Conversion timer; the code word is taken when it expires
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         conv_cnt_reg <= 16'h0000;
         conv_busy_reg <= 1'b0;
         convert_done_o <= 1'b0;
         tx_hold_reg <= 8'h00;
         idle_words_reg <= 12'h000;
         squelched_reg <= 1'b0;
      end else begin
         convert_done_o <= 1'b0;
         if (sample_o) begin
            conv_busy_reg <= 1'b1;
            conv_cnt_reg <= 16'h0000;
         end else if (conv_busy_reg) begin
            conv_cnt_reg <= conv_cnt_reg + 16'h0001;
            if (conv_cnt_reg == CONV_CYCLES[15:0] - 16'h0001) begin
               conv_busy_reg <= 1'b0;
               convert_done_o <= 1'b1;
               tx_hold_reg <= code_next;
               if (!idle_code) begin
                  idle_words_reg <= 12'h000;
                  squelched_reg <= 1'b0;
               end else if (idle_words_reg == `SQUELCH_WORDS - 12'h001) begin
                  squelched_reg <= 1'b1;
               end else begin
                  idle_words_reg <= idle_words_reg + 12'h001;
               end
            end
         end
      end
   end

   // Transmit shifter; the output floats outside the eight bit slots
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         tx_shreg_reg <= 8'h00;
         tx_bits_reg <= `WORD_BITS;
         tx_frame_reg <= 4'h0;
         pcm_out_o <= 1'b1;
         pcm_out_oe_n_o <= 1'b1;
      end else if (!powered) begin
         tx_bits_reg <= `WORD_BITS;
         pcm_out_o <= 1'b1;
         pcm_out_oe_n_o <= 1'b1;
      end else if (tx_strobe_rise) begin
         tx_bits_reg <= 4'h0;
         tx_frame_reg <= (tx_frame_reg == `SIG_FRAMES) ? 4'h0 : tx_frame_reg + 4'h1;
         tx_shreg_reg <= tx_hold_reg;
         if (ab_enable_i && (tx_frame_reg == `SIG_FRAME_A - 4'h1)) begin
            tx_shreg_reg <= {tx_hold_reg[7:1], tx_sig_a_i};
         end
         if (ab_enable_i && (tx_frame_reg == `SIG_FRAME_B - 4'h1)) begin
            tx_shreg_reg <= {tx_hold_reg[7:1], tx_sig_b_i};
         end
      end else if (tx_shift_rise) begin
         if (tx_bits_reg < `WORD_BITS) begin
            pcm_out_o <= tx_shreg_reg[7];
            pcm_out_oe_n_o <= 1'b0;
            tx_shreg_reg <= {tx_shreg_reg[6:0], 1'b0};
            tx_bits_reg <= tx_bits_reg + 4'h1;
         end else begin
            pcm_out_o <= 1'b1;
            pcm_out_oe_n_o <= 1'b1;
         end
      end
   end

   // Receive shifter, signalling capture and sample-and-hold clear
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         rx_shreg_reg <= 8'h00;
         rx_bits_reg <= `WORD_BITS;
         rx_frame_reg <= 4'h0;
         rx_word_o <= 8'h00;
         rx_word_valid_o <= 1'b0;
         rx_sig_a_o <= 1'b0;
         rx_sig_b_o <= 1'b0;
         hold_clear_o <= 1'b0;
      end else begin
         rx_word_valid_o <= 1'b0;
         hold_clear_o <= 1'b0;
         if (!powered) begin
            rx_bits_reg <= `WORD_BITS;
         end else if (rx_strobe_rise) begin
            rx_bits_reg <= 4'h0;
            hold_clear_o <= 1'b1;
            rx_frame_reg <= (rx_frame_reg == `SIG_FRAMES) ? 4'h0 : rx_frame_reg + 4'h1;
         end else if (rx_shift_fall && (rx_bits_reg < `WORD_BITS)) begin
            rx_shreg_reg <= rx_word_next;
            rx_bits_reg <= rx_bits_reg + 4'h1;
            if (rx_bits_reg == `WORD_BITS - 4'h1) begin
               rx_word_o <= rx_word_next;
               rx_word_valid_o <= 1'b1;
               if (ab_enable_i && (rx_frame_reg == `SIG_FRAME_A)) begin
                  rx_sig_a_o <= rx_pcm_i;
               end
               if (ab_enable_i && (rx_frame_reg == `SIG_FRAME_B)) begin
                  rx_sig_b_o <= rx_pcm_i;
               end
            end
         end
      end
   end

   // Strobe watchdog; either strobe edge proves the highway is alive
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         idle_cnt_reg <= 18'h00000;
         power_down_o <= 1'b0;
      end else begin
         if (tx_strobe_rise || rx_strobe_rise) begin
            idle_cnt_reg <= 18'h00000;
         end else if (idle_cnt_reg != IDLE_CYCLES[17:0]) begin
            idle_cnt_reg <= idle_cnt_reg + 18'h00001;
         end
         power_down_o <= ~power_down_n_i || (idle_cnt_reg == IDLE_CYCLES[17:0]);
      end
   end

endmodule

// *** sim/pcm_port_asserts.sv ***
// Concurrent checks on the serial port and timing outputs of the PCM port
module pcm_port_asserts #(
   parameter int CONV_CYCLES = 20
) (
   input wire clk_i,
   input wire reset_n_i,
   input wire master_timing_clock_i,
   input wire [1:0] clk_sel_i,
   input wire power_down_n_i,
   input wire tx_strobe_i,
   input wire tx_shift_i,
   input wire rx_strobe_i,
   input wire pcm_out_o,
   input wire pcm_out_oe_n_o,
   input wire rx_word_valid_o,
   input wire hold_clear_o,
   input wire lpf_tick_o,
   input wire hpf_tick_o,
   input wire sample_o,
   input wire convert_done_o,
   input wire power_down_o
);
   logic [3:0] bit_reg;
   logic [7:0] edge_reg;
   logic [2:0] tick_reg;
   logic armed_reg;
   logic [7:0] div;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // Master edges per filter tick for the selected clock
   assign div = (clk_sel_i == 2'h1) ? 8'h01 : (clk_sel_i == 2'h2) ? 8'h06 : 8'h08;
   // Shift rises since the strobe; 9 means no word in flight
   always @(posedge clk_i) begin
      if (!reset_n_i || power_down_o) bit_reg <= 4'h9;
      else if ($rose(tx_strobe_i)) bit_reg <= 4'h0;
      else if ($rose(tx_shift_i) && bit_reg < 4'h9) bit_reg <= bit_reg + 4'h1;
   end
   // Divider counts; disarmed in power-down since the divider freezes there
   always @(posedge clk_i) begin
      if (!reset_n_i || power_down_o) begin
         edge_reg <= 8'h00;
         tick_reg <= 3'h0;
         armed_reg <= 1'b0;
      end else begin
         if (lpf_tick_o) edge_reg <= {7'h00, $rose(master_timing_clock_i)};
         else if ($rose(master_timing_clock_i)) edge_reg <= edge_reg + 8'h01;
         if (hpf_tick_o) tick_reg <= 3'h0;
         else if (lpf_tick_o) tick_reg <= tick_reg + 3'h1;
         if (hpf_tick_o) armed_reg <= 1'b1;
      end
   end
   a_drive_on_rise: assert property (
      $rose(tx_shift_i) && !$rose(tx_strobe_i) && bit_reg < 4'h8 && !power_down_o |=> !pcm_out_oe_n_o)
      else $error("output not driven after shift rise");
   a_release_after_eighth: assert property (
      $rose(tx_shift_i) && !$rose(tx_strobe_i) && bit_reg == 4'h8 && !power_down_o |=> pcm_out_oe_n_o && pcm_out_o)
      else $error("output not released after eighth bit");
   a_hold_between_rises: assert property (
      !$rose(tx_shift_i) && !$rose(tx_strobe_i) |=> $stable(pcm_out_o) && $stable(pcm_out_oe_n_o))
      else $error("output moved without a shift rise");
   a_clear_pulse: assert property (
      $rose(rx_strobe_i) && !power_down_o |=> hold_clear_o ##1 !hold_clear_o)
      else $error("hold clear pulse missing");
   a_valid_single: assert property (rx_word_valid_o |=> !rx_word_valid_o)
      else $error("receive valid longer than one cycle");
   a_lpf_divide: assert property (lpf_tick_o && armed_reg |-> edge_reg == div)
      else $error("filter tick spacing wrong");
   a_hpf_fourth_tick: assert property (
      hpf_tick_o && armed_reg |-> {1'b0, tick_reg} + {3'h0, lpf_tick_o} == 4'h4)
      else $error("high-pass tick not every fourth");
   a_convert_time: assert property (sample_o && !power_down_o |=> ##CONV_CYCLES convert_done_o)
      else $error("conversion end late or early");
   a_power_pin: assert property (!power_down_n_i |=> power_down_o)
      else $error("no power-down with pin low");
endmodule
bind pcm_port pcm_port_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_asserts (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .master_timing_clock_i(master_timing_clock_i),
   .clk_sel_i(clk_sel_i), .power_down_n_i(power_down_n_i), .tx_strobe_i(tx_strobe_i),
   .tx_shift_i(tx_shift_i), .rx_strobe_i(rx_strobe_i), .pcm_out_o(pcm_out_o),
   .pcm_out_oe_n_o(pcm_out_oe_n_o), .rx_word_valid_o(rx_word_valid_o), .hold_clear_o(hold_clear_o),
   .lpf_tick_o(lpf_tick_o), .hpf_tick_o(hpf_tick_o), .sample_o(sample_o),
   .convert_done_o(convert_done_o), .power_down_o(power_down_o));

// *** sim/highway_framer.sv ***
// Behavioural highway framer on the far side of the PCM port
module highway_framer (
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic [7:0] rx_word_i,
   input wire logic pcm_out_i,
   input wire logic pcm_out_oe_n_i,
   output logic master_o,
   output logic strobe_o,
   output logic shift_o,
   output logic rx_pcm_o,
   output logic [7:0] tx_word_o,
   output logic frame_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] fcnt = 11'h000;
   logic [10:0] d;
   logic [7:0] cap = 8'h00;
   logic line;
   // Pulled-up highway: a released output reads high
   assign line = pcm_out_oe_n_i ? 1'b1 : pcm_out_i;
   assign d = fcnt - 11'h00C;
   // 2048-cycle frame is 256 master periods, so strobe and shift stay locked
   always @(negedge clk_i) begin
      fcnt <= fcnt + 11'h001;
      master_o <= fcnt[2];
      strobe_o <= run_i && fcnt >= 11'h002 && fcnt < 11'h00A;
      shift_o <= run_i && fcnt >= 11'h008 && fcnt < 11'h050 && fcnt[2];
      // Outside the word the data line toggles, so stale bits never match
      rx_pcm_o <= (fcnt >= 11'h00C && fcnt < 11'h04C) ? rx_word_i[~d[5:3]] : fcnt[0];
      frame_done_o <= fcnt == 11'h064;
      if (fcnt[2:0] == 3'h0 && fcnt >= 11'h010 && fcnt <= 11'h048) cap <= {cap[6:0], line};
      if (fcnt == 11'h050) tx_word_o <= cap;
   end
endmodule

// *** sim/companding_codec_pcm_port_tb.sv ***
// Self-checking bench for the serial PCM port
module companding_codec_pcm_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] codes [4] = '{8'hA5, 8'h00, 8'h00, 8'h81};
   localparam logic [7:0] sent [4] = '{8'hA5, 8'h02, 8'h00, 8'h81};
   localparam logic [3:0] laws = 4'hB;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic pd_n = 1'b1, mu = 1'b1, ab_en = 1'b0, sig_a = 1'b0, sig_b = 1'b0, run = 1'b1, sq = 1'b1;
   logic [7:0] code = 8'hA5, rx_in = 8'h5A;
   logic master, strobe, shift, rx_pcm, pcm_out, oe_n, frame_done, valid, pd, rsa, rsb;
   logic [7:0] rx_word, tx_word;
   int fail_count = 0, total_checks = 0, valid_seen = 0;
   // Clock select tied to the 2.048 MHz ratio that the framer's master matches
   pcm_port #(.CONV_CYCLES(20), .IDLE_CYCLES(4000)) u_dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .master_timing_clock_i(master), .clk_sel_i(2'h0),
      .power_down_n_i(pd_n), .mu_law_i(mu), .squelch_en_i(sq), .ab_enable_i(ab_en),
      .tx_strobe_i(strobe), .tx_shift_i(shift), .tx_code_i(code), .tx_sig_a_i(sig_a),
      .tx_sig_b_i(sig_b), .pcm_out_o(pcm_out), .pcm_out_oe_n_o(oe_n), .rx_strobe_i(strobe),
      .rx_shift_i(shift), .rx_pcm_i(rx_pcm), .rx_word_o(rx_word), .rx_word_valid_o(valid),
      .rx_sig_a_o(rsa), .rx_sig_b_o(rsb), .hold_clear_o(), .lpf_tick_o(), .hpf_tick_o(), .sample_o(),
      .convert_done_o(), .power_down_o(pd));
   highway_framer u_framer (.clk_i(clk_i), .run_i(run), .rx_word_i(rx_in), .pcm_out_i(pcm_out),
      .pcm_out_oe_n_i(oe_n), .master_o(master), .strobe_o(strobe), .shift_o(shift),
      .rx_pcm_o(rx_pcm), .tx_word_o(tx_word), .frame_done_o(frame_done));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   // Count receive words per frame, looked at mid-cycle where the pulse is settled
   always @(negedge clk_i) begin
      if (valid === 1'b1) valid_seen++;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic frames(input int n);
      repeat (n) @(posedge frame_done);
      @(negedge clk_i);
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // A new code needs one frame to be converted before it is shifted
   task automatic t_words();
      for (int i = 0; i < 4; i++) begin
         mu <= laws[i];
         code <= codes[i];
         rx_in <= ~codes[i];
         frames(1);
         valid_seen = 0;
         frames(1);
         check(tx_word, sent[i]);
         check(rx_word, ~codes[i]);
         check(8'(valid_seen), 8'h01);
      end
   endtask
   task automatic t_power();
      pd_n <= 1'b0;
      repeat (3) @(negedge clk_i);
      check({7'h00, pd}, 8'h01);
      pd_n <= 1'b1;
      repeat (3) @(negedge clk_i);
      check({7'h00, pd}, 8'h00);
      run <= 1'b0;
      repeat (4100) @(negedge clk_i);
      check({7'h00, pd}, 8'h01);
      run <= 1'b1;
      frames(1);
      check({7'h00, pd}, 8'h00);
   endtask
   // Frames whose LSB is 1 while voice LSB is 0 mark the signalling slot
   // Receive LSB is 1 in every frame when mark is negative, else only in frame mark
   task automatic scan(output int pos, input int mark);
      int ones;
      ones = 0;
      pos = 0;
      for (int k = 0; k < 12; k++) begin
         rx_in <= {7'h00, (mark < 0 || k == mark)};
         frames(1);
         if (tx_word[0] === 1'b1) begin
            ones++;
            pos = k;
         end
      end
      check(8'(ones), 8'h01);
   endtask
   task automatic t_sig();
      int pos_a, pos_b;
      ab_en <= 1'b1;
      code <= 8'hFE;
      sig_a <= 1'b1;
      frames(1);
      scan(pos_a, -1);
      check({6'h00, rsb, rsa}, 8'h03);
      sig_a <= 1'b0;
      sig_b <= 1'b1;
      scan(pos_b, (pos_a + 6) % 12);
      check(8'(pos_b), 8'((pos_a + 6) % 12));
      check({6'h00, rsb, rsa}, 8'h02);
   endtask
   initial begin
      repeat (10) @(negedge clk_i);
      reset_n_i <= 1'b1;
      frames(2);
      t_words();
      t_power();
      t_sig();
      end_sim();
   end
   // Expected run is about 76000 cycles
   initial begin
      repeat (100000) @(posedge clk_i);
      fail_count++;
      end_sim();
   end
endmodule
